// file: hdl/bus_cycle_pkg.sv
/*
  Shared constants and types for the backplane master and slave ends:
  cycle kinds, status line positions, address widths and the cycle timing.
  Assumes one clock at 25 MHz shared by both ends.
*/
package bus_cycle_pkg;

  // Status word bit positions (logic sense, 1 = true)
  localparam int ST_MEMR = 0;
  localparam int ST_M1   = 1;
  localparam int ST_INP  = 2;
  localparam int ST_OUT  = 3;
  localparam int ST_WO   = 4;
  localparam int ST_INTA = 5;
  localparam int ST_HLTA = 6;
  localparam int ST_XTRQ = 7;
  localparam int ST_BITS = 8;

  // Active-low line mask: those lines are electrically low when true
  localparam logic [7:0] ST_LOW_MASK = 8'h90;

  localparam int ADDR_STD_MEM = 16;
  localparam int ADDR_EXT_MEM = 24;
  localparam int ADDR_STD_IO  = 8;
  localparam int ADDR_EXT_IO  = 16;

  // Cycle timing: clock rate and strobe phase length
  localparam int CLK_MHZ       = 25;
  localparam int T_STROBE_NS   = 80;
  localparam int STROBE_CYCLES = (T_STROBE_NS * CLK_MHZ + 999) / 1000;

  localparam int MAX_TEMP_MASTERS = 16;

  typedef enum logic [2:0] {
    CYC_MEMR  = 3'h0,
    CYC_M1    = 3'h1,
    CYC_MEMW  = 3'h2,
    CYC_INP   = 3'h3,
    CYC_OUT   = 3'h4,
    CYC_INTA  = 3'h5,
    CYC_HLTA  = 3'h6
  } cycle_type;

  // Logic-sense status word for each cycle kind; word flag sets sixteen request except on INTA and HLTA
  function automatic logic [7:0] status_of(input cycle_type kind, input logic word);
    logic [7:0] s;
    s = 8'h00;
    unique case (kind)
      CYC_MEMR: s[ST_MEMR] = 1'b1;
      CYC_M1:   begin
        s[ST_MEMR] = 1'b1;
        s[ST_M1]   = 1'b1;
      end
      CYC_MEMW: s[ST_WO] = 1'b1;
      CYC_INP:  s[ST_INP] = 1'b1;
      CYC_OUT:  begin
        s[ST_OUT] = 1'b1;
        s[ST_WO]  = 1'b1;
      end
      CYC_INTA: s[ST_INTA] = 1'b1;
      CYC_HLTA: s[ST_HLTA] = 1'b1;
      default:  s = 8'h00;
    endcase
    s[ST_XTRQ] = word & (kind != CYC_INTA) & (kind != CYC_HLTA);
    return s;
  endfunction

endpackage

// file: hdl/bus_link_if.sv
/*
  Backplane lines between one master end and one slave end.
  Status lines carry electrical levels; the two active-low ones are low when true.
  Assumes the bench joins one master and one slave end on a common clock.
*/
`timescale 1ns/1ps
interface bus_link_if;
  logic [23:0] addr;
  logic [7:0]  status_e;
  logic        sync;
  logic        dbin;
  logic        wr_n;
  logic [7:0]  dout;
  logic [7:0]  din;
  logic        sixtn_n;
  logic        hold_n;
  logic        hlda;

  modport master (
    output addr,
    output status_e,
    output sync,
    output dbin,
    output wr_n,
    output dout,
    input  din,
    input  sixtn_n,
    input  hold_n,
    output hlda
  );

  modport slave (
    input  addr,
    input  status_e,
    input  sync,
    input  dbin,
    input  wr_n,
    input  dout,
    output din,
    output sixtn_n,
    output hold_n,
    input  hlda
  );
endinterface

// file: hdl/bus_slave_end.sv
/*
  Slave end: watches every bus cycle, decodes memory or I/O address
  windows, and answers reads or takes writes. Can request the bus as a
  temporary master via a request line.
  Assumes the master end drives status and address for the whole cycle.
*/
`timescale 1ns/1ps
module bus_slave_end
  import bus_cycle_pkg::*;
#(
  parameter logic [23:0] MEM_BASE = 24'h00_0000,
  parameter logic [23:0] MEM_MASK = 24'hFF_F000,
  parameter logic [15:0] IO_BASE  = 16'h0010,
  parameter logic [15:0] IO_MASK  = 16'hFFF0,
  parameter logic        EXTENDED = 1'b0,
  parameter logic        WORD_OK  = 1'b1
) (
  input  wire logic         MCLK,
  input  wire logic         RSTN,
  bus_link_if.slave         LINK,
  input  wire logic [15:0]  RD_DATA,
  output logic              WR_STB,
  output logic              RD_STB,
  output logic              MEM_HIT,
  output logic [23:0]       SEEN_ADDR,
  output logic [15:0]       WR_DATA,
  input  wire logic         DMA_REQ
);

  wire [7:0]  st          = LINK.status_e ^ ST_LOW_MASK;
  // Memory write is derived, never a line of its own
  wire        mem_write   = ~st[ST_OUT] & st[ST_WO];
  wire        mem_cyc     = st[ST_MEMR] | mem_write;
  wire        io_cyc      = st[ST_INP] | st[ST_OUT];
  // Acknowledge cycles carry no address worth decoding
  wire        ack_cyc     = st[ST_INTA] | st[ST_HLTA];
  wire [23:0] mem_a       = EXTENDED ? LINK.addr : {8'h00, LINK.addr[15:0]};
  wire [15:0] io_a        = EXTENDED ? LINK.addr[15:0] : {8'h00, LINK.addr[7:0]};
  wire        mem_sel     = mem_cyc & ((mem_a & MEM_MASK) == (MEM_BASE & MEM_MASK));
  wire        io_sel      = io_cyc & ((io_a & IO_MASK) == (IO_BASE & IO_MASK));
  wire        hit         = ~ack_cyc & (mem_sel | io_sel);
  wire        word        = st[ST_XTRQ] & WORD_OK & hit;
  wire        gang        = word & ~LINK.sixtn_n;

  logic [23:0] seen_addr_ff;
  logic        mem_hit_ff;
  logic [15:0] wr_data_ff;
  logic        wr_stb_ff;
  logic        rd_stb_ff;
  logic        wr_q_ff;

  assign LINK.sixtn_n = ~word;
  assign LINK.hold_n  = ~DMA_REQ;
  // Ganged word read: high byte returns on the input lines; the low byte is not driven back
  wire [7:0]  din_byte    = gang ? RD_DATA[15:8] : RD_DATA[7:0];
  assign LINK.din     = (hit & LINK.dbin) ? din_byte : 8'h00;

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      seen_addr_ff <= 24'h00_0000;
      mem_hit_ff   <= 1'b0;
      wr_data_ff   <= 16'h0000;
      wr_stb_ff    <= 1'b0;
      rd_stb_ff    <= 1'b0;
      wr_q_ff      <= 1'b0;
    end else begin
      wr_q_ff   <= ~LINK.wr_n;
      wr_stb_ff <= hit & ~LINK.wr_n & ~wr_q_ff;
      rd_stb_ff <= hit & LINK.sync & ~LINK.wr_n & 1'b0 | hit & LINK.sync & st[ST_MEMR]
                   | hit & LINK.sync & st[ST_INP];
      if (LINK.sync & hit) begin
        seen_addr_ff <= LINK.addr;
        mem_hit_ff   <= mem_sel;
      end
      if (hit & ~LINK.wr_n & ~wr_q_ff) begin
        wr_data_ff <= gang ? {LINK.din, LINK.dout} : {8'h00, LINK.dout};
      end
    end
  end

  assign WR_STB    = wr_stb_ff;
  assign RD_STB    = rd_stb_ff;
  assign MEM_HIT   = mem_hit_ff;
  assign SEEN_ADDR = seen_addr_ff;
  assign WR_DATA   = wr_data_ff;

endmodule

// file: hdl/bus_master_end.sv
/*
  Master end: turns user requests into complete bus cycles, driving
  address, all eight status lines and the control strobes. Acts as the
  permanent master or as a temporary master.
  Assumes a user that holds a request until it is accepted; one slave end.
*/
// How it works
// - Master starts cycles, drives address status control
// - All transfers ride master-made cycles
// - Slave watches every cycle, answers when addressed
// - Slave needs only signals it uses
// - One permanent master, up to sixteen temporary
// - Temporary master borrows bus, then returns it
// - Temporary master never yields to nested DMA
// - At least 16 address lines, optionally 24
// - Standard memory cycles: 16-bit address
// - Extended memory cycles: 24-bit address
// - Standard I/O cycles: 8-bit address
// - Extended I/O cycles: 16-bit address
// - Optional I/O address copy into upper byte
// - Master drives all eight status lines
// - Memory write derived from two status lines
// - Memory write is not output and write
// - Asterisk lines are true when low
// - Both sixteen lines true gang data buses; here ganged reads return only the high byte, ganged writes only the low byte
`timescale 1ns/1ps
module bus_master_end
  import bus_cycle_pkg::*;
#(
  parameter logic PERMANENT = 1'b1,
  parameter logic EXTENDED  = 1'b0,
  parameter logic IO_COPY   = 1'b0,
  parameter int   STROBE_N  = STROBE_CYCLES
) (
  input  wire logic         MCLK,
  input  wire logic         RSTN,
  bus_link_if.master        LINK,
  input  wire logic         REQ_VALID,
  output logic              REQ_READY,
  input  wire cycle_type    REQ_KIND,
  input  wire logic         REQ_WORD,
  input  wire logic [23:0]  REQ_ADDR,
  input  wire logic [15:0]  REQ_WDATA,
  output logic              RSP_VALID,
  output logic [15:0]       RSP_RDATA,
  output logic              RSP_WORD,
  input  wire logic         HOLD_EN,
  output logic              BUS_OWNED
);

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0001,
    S_SYNC   = 4'b0010,
    S_STROBE = 4'b0100,
    S_HELD   = 4'b1000
  } state_type;

  localparam logic [7:0] CNT_LOAD = 8'(STROBE_N);

  state_type   state_ff;
  state_type   nxt_state;
  logic [23:0] addr_ff;
  logic [7:0]  stat_ff;
  logic [15:0] wdata_ff;
  logic [7:0]  cnt_ff;
  logic        sync_ff;
  logic        dbin_ff;
  logic        wr_ff;
  logic        word_ff;
  cycle_type   kind_ff;
  logic        rsp_valid_ff;
  logic [15:0] rsp_rdata_ff;
  logic        rsp_word_ff;

  // Width of the address actually driven depends on mode and cycle kind
  function automatic logic [23:0] addr_of(input cycle_type k, input logic [23:0] a);
    logic [23:0] r;
    r = 24'h00_0000;
    unique case (k)
      CYC_MEMR, CYC_M1, CYC_MEMW:
        r = EXTENDED ? a : {8'h00, a[15:0]};
      CYC_INP, CYC_OUT: begin
        if (EXTENDED) begin
          r = {8'h00, a[15:0]};
        end else if (IO_COPY) begin
          r = {8'h00, a[7:0], a[7:0]};
        end else begin
          r = {16'h0000, a[7:0]};
        end
      end
      default: r = 24'h00_0000;
    endcase
    return r;
  endfunction

  // Only the permanent master grants the bus; a temporary one never nests
  wire hold_req   = PERMANENT & HOLD_EN & ~LINK.hold_n;
  wire take       = (state_ff == S_IDLE) & REQ_VALID & ~hold_req;
  wire cnt_done   = (cnt_ff == 8'h00);
  wire is_read    = kind_ff == CYC_MEMR || kind_ff == CYC_M1 || kind_ff == CYC_INP
                    || kind_ff == CYC_INTA;
  wire is_write   = kind_ff == CYC_MEMW || kind_ff == CYC_OUT;
  wire ganged     = word_ff & ~LINK.sixtn_n;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE:   begin
        if (hold_req) begin
          nxt_state = S_HELD;
        end else if (REQ_VALID) begin
          nxt_state = S_SYNC;
        end
      end
      S_SYNC:   nxt_state = S_STROBE;
      S_STROBE: begin
        if (cnt_done) begin
          nxt_state = S_IDLE;
        end
      end
      S_HELD:   begin
        if (LINK.hold_n) begin
          nxt_state = S_IDLE;
        end
      end
      default:  nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      state_ff <= S_IDLE;
      cnt_ff   <= 8'h00;
      sync_ff  <= 1'b0;
      dbin_ff  <= 1'b0;
      wr_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sync_ff  <= take;
      if (state_ff == S_SYNC) begin
        cnt_ff  <= CNT_LOAD - 8'h01;
        dbin_ff <= is_read;
        wr_ff   <= is_write;
      end else if (state_ff == S_STROBE && !cnt_done) begin
        cnt_ff <= cnt_ff - 8'h01;
      end else begin
        dbin_ff <= 1'b0;
        wr_ff   <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      addr_ff  <= 24'h00_0000;
      stat_ff  <= 8'h00;
      wdata_ff <= 16'h0000;
      word_ff  <= 1'b0;
      kind_ff  <= CYC_MEMR;
    end else if (take) begin
      addr_ff  <= addr_of(REQ_KIND, REQ_ADDR);
      stat_ff  <= status_of(REQ_KIND, REQ_WORD);
      wdata_ff <= REQ_WDATA;
      word_ff  <= REQ_WORD;
      kind_ff  <= REQ_KIND;
    end else if (state_ff == S_IDLE) begin
      stat_ff <= 8'h00;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= 16'h0000;
      rsp_word_ff  <= 1'b0;
    end else begin
      rsp_valid_ff <= (state_ff == S_STROBE) & cnt_done;
      if ((state_ff == S_STROBE) && cnt_done && is_read) begin
        rsp_rdata_ff <= ganged ? {LINK.din, 8'h00} : {8'h00, LINK.din};
        rsp_word_ff  <= ganged;
      end
    end
  end

  // Held bus: address and status lines parked idle while a temporary master owns it
  wire drive = state_ff != S_HELD;
  assign LINK.addr     = drive ? addr_ff : 24'h00_0000;
  // Active-low status lines inverted to electrical level
  assign LINK.status_e = (drive ? stat_ff : 8'h00) ^ ST_LOW_MASK;
  assign LINK.sync     = sync_ff;
  assign LINK.dbin     = dbin_ff;
  assign LINK.wr_n     = ~wr_ff;
  assign LINK.dout     = ganged & dbin_ff ? 8'h00 : wdata_ff[7:0];
  assign LINK.hlda     = state_ff == S_HELD;

  assign REQ_READY = take;
  assign RSP_VALID = rsp_valid_ff;
  assign RSP_RDATA = rsp_rdata_ff;
  assign RSP_WORD  = rsp_word_ff;
  assign BUS_OWNED = drive;

endmodule

// file: tb/bus_link_monitor.sv
/*
  Checker on the backplane lines between the master and slave ends.
  Assumes one clock, standard addressing, no I/O address copy, default strobe length.
*/
`timescale 1ns/1ps
module bus_link_monitor
  import bus_cycle_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RSTN,
  input wire logic [23:0] addr,
  input wire logic [7:0]  status_e,
  input wire logic        sync,
  input wire logic        dbin,
  input wire logic        wr_n,
  input wire logic        hlda
);
  logic [7:0] st;
  logic       mem_c;
  logic       io_c;
  logic       ack_c;
  // Logic sense: the two active-low lines are flipped back
  assign st    = status_e ^ ST_LOW_MASK;
  assign mem_c = st[ST_MEMR] | (st[ST_WO] & ~st[ST_OUT]);
  assign io_c  = st[ST_INP] | st[ST_OUT];
  assign ack_c = st[ST_INTA] | st[ST_HLTA];

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  sequence strobe_s;
    (dbin | ~wr_n)[*2];
  endsequence
  sequence quiet_s;
    (~sync)[*3];
  endsequence

  a_one_kind: assert property (sync |-> $onehot({st[ST_MEMR], st[ST_WO] & ~st[ST_OUT],
    st[ST_INP], st[ST_OUT], st[ST_INTA], st[ST_HLTA]})) else $error("cycle kind ambiguous");
  a_fetch_reads_mem: assert property (sync && st[ST_M1] |-> st[ST_MEMR] && !st[ST_WO])
    else $error("fetch without memory read");
  a_ack_no_addr: assert property (sync && ack_c |-> addr == 24'h00_0000 && !st[ST_XTRQ])
    else $error("acknowledge cycle carries address");
  a_std_mem_addr: assert property (sync && mem_c |-> addr[23:16] == 8'h00)
    else $error("memory address too wide");
  a_std_io_addr: assert property (sync && io_c |-> addr[23:8] == 16'h0000)
    else $error("io address too wide");
  a_strobe_follows: assert property (sync && !ack_c |=> strobe_s)
    else $error("strobe missing after cycle start");
  a_write_kind: assert property (!wr_n |-> st[ST_WO] && !dbin)
    else $error("write strobe without write status");
  a_read_kind: assert property (dbin |-> st[ST_MEMR] | st[ST_INP] | st[ST_INTA])
    else $error("read strobe without read status");
  a_sync_spacing: assert property (sync |=> quiet_s)
    else $error("cycles too close");
  a_addr_holds: assert property (sync |=> ($stable(addr) && $stable(status_e))[*3])
    else $error("address or status moved in cycle");
  a_hold_quiet: assert property (hlda |-> !sync && !dbin && wr_n)
    else $error("cycle while bus handed over");
endmodule

// file: tb/s100_master_address_status_tb.sv
/*
  Bench joining one master end and one slave end through the link interface.
  Assumes slave windows at their defaults and standard addressing.
*/
`timescale 1ns/1ps
module s100_master_address_status_tb;
  import bus_cycle_pkg::*;
  logic        mclk;
  logic        rstn;
  logic        req_valid;
  logic        req_ready;
  cycle_type   req_kind;
  logic        req_word;
  logic [23:0] req_addr;
  logic [15:0] req_wdata;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  logic        rsp_word;
  logic        bus_owned;
  logic        dma_req;
  logic        wr_stb;
  logic        mem_hit;
  logic [23:0] seen_addr;
  logic [15:0] wr_data;
  logic [7:0]  st_seen;
  logic [23:0] ad_seen;
  int          wr_cnt = 0;
  int          cyc = 0;
  int          mismatches = 0;
  int          cmp_count = 0;

  bus_link_if link();
  bus_master_end i_bus_master_end (.MCLK(mclk), .RSTN(rstn), .LINK(link),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_KIND(req_kind), .REQ_WORD(req_word),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
    .RSP_WORD(rsp_word), .HOLD_EN(1'b1), .BUS_OWNED(bus_owned));
  bus_slave_end i_bus_slave_end (.MCLK(mclk), .RSTN(rstn), .LINK(link),
    .RD_DATA(16'hA5C3), .WR_STB(wr_stb), .RD_STB(), .MEM_HIT(mem_hit), .SEEN_ADDR(seen_addr),
    .WR_DATA(wr_data), .DMA_REQ(dma_req));
  bus_link_monitor i_bus_link_monitor (.MCLK(mclk), .RSTN(rstn), .addr(link.addr),
    .status_e(link.status_e), .sync(link.sync), .dbin(link.dbin), .wr_n(link.wr_n),
    .hlda(link.hlda));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (link.sync === 1'b1) begin
      st_seen <= link.status_e;
      ad_seen <= link.addr;
    end
    if (wr_stb === 1'b1) wr_cnt <= wr_cnt + 1;
    cyc <= cyc + 1;
    // Whole run needs well under a hundred cycles
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Entered at a falling edge; returns at the falling edge that shows the response
  task automatic run(input cycle_type k, input logic w, input logic [23:0] a,
                     input logic [15:0] d, input logic [23:0] ea);
    logic [7:0] ls;
    ls = 8'h00;
    case (k)
      CYC_MEMR: ls = 8'h01;
      CYC_M1:   ls = 8'h03;
      CYC_MEMW: ls = 8'h10;
      CYC_INP:  ls = 8'h04;
      CYC_OUT:  ls = 8'h18;
      CYC_INTA: ls = 8'h20;
      default:  ls = 8'h40;
    endcase
    ls[7] = w;
    req_kind = k;
    req_word = w;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    // Ready is looked at on the edge that takes the request, never at once
    @(posedge mclk);
    while (req_ready !== 1'b1) @(posedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1) @(negedge mclk);
    chk("status lines", {16'h0000, ls ^ ST_LOW_MASK}, {16'h0000, st_seen});
    chk("address lines", ea, ad_seen);
  endtask

  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_kind = CYC_MEMR;
    req_word = 1'b0;
    req_addr = 24'h00_0000;
    req_wdata = 16'h0000;
    dma_req = 1'b0;
    repeat (3) @(negedge mclk);
    chk("idle status", {16'h0000, ST_LOW_MASK}, {16'h0000, link.status_e});
    rstn = 1'b1;
    run(CYC_MEMW, 1'b0, 24'h00_0123, 16'h005A, 24'h00_0123);
    chk("write data", 24'h00_005A, {16'h0000, wr_data[7:0]});
    chk("seen address", 24'h00_0123, seen_addr);
    chk("write strobes", 24'h00_0001, 24'(wr_cnt));
    chk("memory hit", 24'h00_0001, {23'h00_0000, mem_hit});
    run(CYC_MEMR, 1'b0, 24'h00_0FFF, 16'h0000, 24'h00_0FFF);
    chk("read byte", 24'h00_00C3, {16'h0000, rsp_rdata[7:0]});
    run(CYC_M1, 1'b0, 24'h00_0010, 16'h0000, 24'h00_0010);
    chk("fetch byte", 24'h00_00C3, {16'h0000, rsp_rdata[7:0]});
    run(CYC_OUT, 1'b0, 24'h00_001F, 16'h003C, 24'h00_001F);
    chk("out data", 24'h00_003C, {16'h0000, wr_data[7:0]});
    chk("out strobes", 24'h00_0002, 24'(wr_cnt));
    chk("io hit", 24'h00_0000, {23'h00_0000, mem_hit});
    run(CYC_INP, 1'b0, 24'h00_0010, 16'h0000, 24'h00_0010);
    chk("in byte", 24'h00_00C3, {16'h0000, rsp_rdata[7:0]});
    run(CYC_MEMR, 1'b1, 24'h00_0100, 16'h0000, 24'h00_0100);
    chk("word flag", 24'h00_0001, {23'h00_0000, rsp_word});
    chk("word high", 24'h00_00A5, {16'h0000, rsp_rdata[15:8]});
    run(CYC_INTA, 1'b0, 24'h00_0123, 16'h0000, 24'h00_0000);
    run(CYC_HLTA, 1'b0, 24'h00_0123, 16'h0000, 24'h00_0000);
    dma_req = 1'b1;
    while (link.hlda !== 1'b1) @(negedge mclk);
    req_valid = 1'b1;
    @(negedge mclk);
    chk("ready while held", 24'h00_0000, {23'h00_0000, req_ready});
    chk("owned while held", 24'h00_0000, {23'h00_0000, bus_owned});
    dma_req = 1'b0;
    @(negedge mclk);
    run(CYC_MEMR, 1'b0, 24'h00_0200, 16'h0000, 24'h00_0200);
    report_and_stop();
  end
endmodule
